/* hw/jcu_params.svh */
// constants for the debug-link character uart: offsets, fields, sizes
`ifndef JCU_PARAMS_SVH
`define JCU_PARAMS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define JCU_ADDR_DATA 32'hff201000
`define JCU_ADDR_CTRL 32'hff201004

// ****************************************************************
// data register fields
// ****************************************************************
`define JCU_DATA_CHAR_LSB 0
`define JCU_DATA_CHAR_MSB 7
`define JCU_DATA_VALID_BIT 15
`define JCU_DATA_COUNT_LSB 16
`define JCU_DATA_COUNT_MSB 31

// ****************************************************************
// control register fields
// ****************************************************************
`define JCU_CTRL_RX_EN_BIT 0
`define JCU_CTRL_TX_EN_BIT 1
`define JCU_CTRL_RX_PEND_BIT 8
`define JCU_CTRL_TX_PEND_BIT 9
`define JCU_CTRL_SEEN_BIT 10
`define JCU_CTRL_SPACE_LSB 16
`define JCU_CTRL_SPACE_MSB 31

// ****************************************************************
// queue sizes, thresholds, reset values
// ****************************************************************
`define JCU_DEPTH 7'h40
`define JCU_PTR_W 6
`define JCU_CNT_W 7
`define JCU_CHAR_W 8
`define JCU_IRQ_LEVEL 7'h07
`define JCU_RST_ENABLE 1'b0
`define JCU_RST_SEEN 1'b0

// ****************************************************************
// link frame layout: bit0 host sends, bit1 host fetches, bits 9:2 char
// ****************************************************************
`define JCU_FRAME_BITS 4'ha
`define JCU_FRAME_SEND_BIT 0
`define JCU_FRAME_FETCH_BIT 1
`define JCU_FRAME_CHAR_LSB 2
`define JCU_FRAME_CHAR_MSB 9

`endif

/* hw/jcu_pkg.sv */
// types shared by the debug-link character uart
package jcu_pkg;

    typedef enum logic [1:0] {
        JCU_LINK_IDLE = 2'b00,
        JCU_LINK_SHIFT = 2'b01
    } jcu_link_state_t;

    typedef logic [7:0] jcu_char_t;

endpackage

/* hw/jcu_fifo.sv */
// flip-flop character queue with fill count, drops pushes when full unless a same-cycle pop frees a slot
`timescale 1ns/100ps
`include "jcu_params.svh"

module jcu_fifo
    import jcu_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // fill side
    input wire logic push,
    input wire jcu_char_t push_data,
    // drain side
    input wire logic pop,
    output jcu_char_t head,
    // state
    output logic [`JCU_CNT_W-1:0] count
);

    jcu_char_t mem_reg [0:`JCU_DEPTH-1];
    jcu_char_t mem_next [0:`JCU_DEPTH-1];
    logic [`JCU_PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [`JCU_PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [`JCU_CNT_W-1:0] count_reg, count_next;
    logic do_push;
    logic do_pop;

    assign head = mem_reg[rd_ptr_reg];
    assign count = count_reg;

    always_comb begin
        do_pop = pop && (count_reg != '0);
        // full queue keeps its contents; a same-cycle pop frees a slot
        do_push = push && ((count_reg != `JCU_DEPTH) || do_pop);
        mem_next = mem_reg;
        rd_ptr_next = rd_ptr_reg;
        wr_ptr_next = wr_ptr_reg;
        count_next = count_reg;
        if (do_push) begin
            mem_next[wr_ptr_reg] = push_data;
            wr_ptr_next = wr_ptr_reg + 6'h01;
        end
        if (do_pop) begin
            rd_ptr_next = rd_ptr_reg + 6'h01;
        end
        if (do_push && !do_pop) begin
            count_next = count_reg + 7'h01;
        end else if (do_pop && !do_push) begin
            count_next = count_reg - 7'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            rd_ptr_reg <= rd_ptr_next;
            wr_ptr_reg <= wr_ptr_next;
            count_reg <= count_next;
        end
    end

    // storage needs no reset: the count marks which reads of it are valid
    always_ff @(posedge core_clk) begin
        mem_reg <= mem_next;
    end

endmodule

/* hw/jcu_top.sv */
// debug-link character uart: processor registers, two queues, link shifter
//
// Overview of operation
// - Data register at base, control register four bytes above, both 32 bits.
// - Characters from host wait in a 64-entry receive queue, in order.
// - Data register bits 31:16 give receive queue fill count left after the read.
// - Characters arriving at a full receive queue are dropped, queue unchanged, unless a data read in the same cycle frees a slot.
// - Empty receive queue reads valid bit zero, char field undefined.
// - Characters for the host wait in a separate 64-entry transmit queue.
// - Data write appends bits 7:0 to transmit queue, receive side untouched.
// - Control register bits 31:16 give free transmit slots.
// - Write with transmit queue full is dropped, queue unchanged, unless a link fetch in the same cycle frees a slot.
// - Control bit 10 sets once the host accesses the uart.
// - Writing one to control bit 10 clears the host-seen flag.
// - Enabled interrupt requested when rx count or tx space exceeds seven.
// - Pending flags show in control register, clear as characters move.
// - Enables at control bits 0 and 1, pending at bits 8 and 9.
`timescale 1ns/100ps
`include "jcu_params.svh"

module jcu_top
    import jcu_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // processor register port
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [31:0] cpu_wdata,
    output logic [31:0] cpu_rdata,
    output logic cpu_rvalid,
    // interrupt request
    output logic irq,
    // debug link pins; inputs from the link's clock domain, link_tdo registered on core_clk
    input wire logic link_tck,
    input wire logic link_sel,
    input wire logic link_tdi,
    output logic link_tdo
);

    // ****************************************************************
    // link pin synchronisers and edge detection
    // ****************************************************************
    logic [2:0] tck_sync_reg, tck_sync_next;
    logic [2:0] sel_sync_reg, sel_sync_next;
    logic [1:0] tdi_sync_reg, tdi_sync_next;
    logic tck_rise;
    logic tck_fall;
    logic sel_rise;
    logic sel_fall;

    always_comb begin
        tck_sync_next = {tck_sync_reg[1:0], link_tck};
        sel_sync_next = {sel_sync_reg[1:0], link_sel};
        tdi_sync_next = {tdi_sync_reg[0], link_tdi};
        // only stages 1 and 2 are read; stage 0 feeds stage 1 alone
        tck_rise = tck_sync_reg[1] && !tck_sync_reg[2];
        tck_fall = !tck_sync_reg[1] && tck_sync_reg[2];
        sel_rise = sel_sync_reg[1] && !sel_sync_reg[2];
        sel_fall = !sel_sync_reg[1] && sel_sync_reg[2];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tck_sync_reg <= '0;
            sel_sync_reg <= '0;
            tdi_sync_reg <= '0;
        end else begin
            tck_sync_reg <= tck_sync_next;
            sel_sync_reg <= sel_sync_next;
            tdi_sync_reg <= tdi_sync_next;
        end
    end

    // ****************************************************************
    // queues
    // ****************************************************************
    logic rx_push;
    jcu_char_t rx_push_data;
    logic rx_pop;
    jcu_char_t rx_head;
    logic [`JCU_CNT_W-1:0] rx_count;
    logic tx_push;
    logic tx_pop;
    jcu_char_t tx_head;
    logic [`JCU_CNT_W-1:0] tx_count;
    logic [`JCU_CNT_W-1:0] tx_space;

    jcu_fifo u_rx_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .push(rx_push),
        .push_data(rx_push_data),
        .pop(rx_pop),
        .head(rx_head),
        .count(rx_count)
    );

    jcu_fifo u_tx_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .push(tx_push),
        .push_data(cpu_wdata[`JCU_DATA_CHAR_MSB:`JCU_DATA_CHAR_LSB]),
        .pop(tx_pop),
        .head(tx_head),
        .count(tx_count)
    );

    assign tx_space = `JCU_DEPTH - tx_count;

    // ****************************************************************
    // link frame shifter
    // ****************************************************************
    jcu_link_state_t link_state_reg, link_state_next;
    logic [`JCU_FRAME_BITS-1:0] in_shift_reg, in_shift_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [8:0] out_shift_reg, out_shift_next;
    logic tx_offered_reg, tx_offered_next;
    logic link_tdo_reg, link_tdo_next;
    logic frame_done;

    always_comb begin
        link_state_next = link_state_reg;
        in_shift_next = in_shift_reg;
        bit_cnt_next = bit_cnt_reg;
        out_shift_next = out_shift_reg;
        tx_offered_next = tx_offered_reg;
        link_tdo_next = link_tdo_reg;
        frame_done = 1'b0;
        unique case (link_state_reg)
            JCU_LINK_IDLE: begin
                if (sel_rise) begin
                    // first bit out tells the host whether a char is offered
                    tx_offered_next = (tx_count != '0);
                    out_shift_next = {tx_head, 1'b0};
                    link_tdo_next = (tx_count != '0);
                    bit_cnt_next = '0;
                    link_state_next = JCU_LINK_SHIFT;
                end
            end
            JCU_LINK_SHIFT: begin
                if (sel_fall) begin
                    // short frames are ignored whole; long frames keep only their first ten rises
                    frame_done = (bit_cnt_reg == `JCU_FRAME_BITS);
                    link_tdo_next = 1'b0;
                    link_state_next = JCU_LINK_IDLE;
                end else begin
                    if (tck_rise && (bit_cnt_reg != `JCU_FRAME_BITS)) begin
                        in_shift_next = {tdi_sync_reg[1], in_shift_reg[`JCU_FRAME_BITS-1:1]};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    if (tck_fall) begin
                        link_tdo_next = out_shift_reg[1];
                        out_shift_next = {1'b0, out_shift_reg[8:1]};
                    end
                end
            end
            default: begin
                link_state_next = JCU_LINK_IDLE;
            end
        endcase
        rx_push = frame_done && in_shift_reg[`JCU_FRAME_SEND_BIT];
        rx_push_data = in_shift_reg[`JCU_FRAME_CHAR_MSB:`JCU_FRAME_CHAR_LSB];
        tx_pop = frame_done && in_shift_reg[`JCU_FRAME_FETCH_BIT] && tx_offered_reg;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            link_state_reg <= JCU_LINK_IDLE;
            in_shift_reg <= '0;
            bit_cnt_reg <= '0;
            out_shift_reg <= '0;
            tx_offered_reg <= 1'b0;
            link_tdo_reg <= 1'b0;
        end else begin
            link_state_reg <= link_state_next;
            in_shift_reg <= in_shift_next;
            bit_cnt_reg <= bit_cnt_next;
            out_shift_reg <= out_shift_next;
            tx_offered_reg <= tx_offered_next;
            link_tdo_reg <= link_tdo_next;
        end
    end

    assign link_tdo = link_tdo_reg;

    // ****************************************************************
    // processor registers
    // ****************************************************************
    logic rx_en_reg, rx_en_next;
    logic tx_en_reg, tx_en_next;
    logic seen_reg, seen_next;
    logic rx_pend_reg, rx_pend_next;
    logic tx_pend_reg, tx_pend_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic irq_reg, irq_next;
    logic hit_data;
    logic hit_ctrl;
    logic [`JCU_CNT_W-1:0] rx_count_after;

    always_comb begin
        hit_data = (cpu_addr == `JCU_ADDR_DATA);
        hit_ctrl = (cpu_addr == `JCU_ADDR_CTRL);
        rx_pop = cpu_rd && hit_data;
        tx_push = cpu_wr && hit_data;
        rx_count_after = (rx_count != '0) ? (rx_count - 7'h01) : rx_count;
        rx_en_next = rx_en_reg;
        tx_en_next = tx_en_reg;
        // host access wins over a same-cycle software clear
        seen_next = seen_reg;
        if (cpu_wr && hit_ctrl) begin
            rx_en_next = cpu_wdata[`JCU_CTRL_RX_EN_BIT];
            tx_en_next = cpu_wdata[`JCU_CTRL_TX_EN_BIT];
            if (cpu_wdata[`JCU_CTRL_SEEN_BIT]) begin
                seen_next = 1'b0;
            end
        end
        if (frame_done) begin
            seen_next = 1'b1;
        end
        // pending follows the levels, so moving chars clears it
        rx_pend_next = rx_en_next && (rx_count > `JCU_IRQ_LEVEL);
        tx_pend_next = tx_en_next && (tx_space > `JCU_IRQ_LEVEL);
        irq_next = rx_pend_reg || tx_pend_reg;
        rvalid_next = cpu_rd && (hit_data || hit_ctrl);
        rdata_next = '0;
        if (cpu_rd && hit_data) begin
            rdata_next[`JCU_DATA_COUNT_MSB:`JCU_DATA_COUNT_LSB] = {9'h000, rx_count_after};
            rdata_next[`JCU_DATA_VALID_BIT] = (rx_count != '0);
            rdata_next[`JCU_DATA_CHAR_MSB:`JCU_DATA_CHAR_LSB] = rx_head;
        end else if (cpu_rd && hit_ctrl) begin
            rdata_next[`JCU_CTRL_SPACE_MSB:`JCU_CTRL_SPACE_LSB] = {9'h000, tx_space};
            rdata_next[`JCU_CTRL_SEEN_BIT] = seen_reg;
            rdata_next[`JCU_CTRL_TX_PEND_BIT] = tx_pend_reg;
            rdata_next[`JCU_CTRL_RX_PEND_BIT] = rx_pend_reg;
            rdata_next[`JCU_CTRL_TX_EN_BIT] = tx_en_reg;
            rdata_next[`JCU_CTRL_RX_EN_BIT] = rx_en_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_en_reg <= `JCU_RST_ENABLE;
            tx_en_reg <= `JCU_RST_ENABLE;
            seen_reg <= `JCU_RST_SEEN;
            rx_pend_reg <= 1'b0;
            tx_pend_reg <= 1'b0;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            rx_en_reg <= rx_en_next;
            tx_en_reg <= tx_en_next;
            seen_reg <= seen_next;
            rx_pend_reg <= rx_pend_next;
            tx_pend_reg <= tx_pend_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            irq_reg <= irq_next;
        end
    end

    assign cpu_rdata = rdata_reg;
    assign cpu_rvalid = rvalid_reg;
    assign irq = irq_reg;

endmodule

/* test/jcu_top_props.sv */
// assertions on the character uart's register and link ports
`timescale 1ns/100ps
`include "jcu_params.svh"

module jcu_top_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [31:0] cpu_wdata,
    input wire logic [31:0] cpu_rdata,
    input wire logic cpu_rvalid,
    // interrupt and link
    input wire logic irq,
    input wire logic link_tck,
    input wire logic link_sel,
    input wire logic link_tdi,
    input wire logic link_tdo
);
    // ****
    // helper state
    // ****
    logic [1:0] en_reg;
    logic [1:0] en_next;
    logic map_rd;
    logic rd_data;
    logic rd_ctrl;

    assign map_rd = cpu_rd && (cpu_addr == `JCU_ADDR_DATA || cpu_addr == `JCU_ADDR_CTRL);

    // enables mirrored from control writes, so irq can be judged at the ports
    always_comb begin
        en_next = en_reg;
        if (cpu_wr && cpu_addr == `JCU_ADDR_CTRL) begin
            en_next = cpu_wdata[1:0];
        end
    end
    always_ff @(posedge core_clk) begin
        en_reg <= srst ? 2'h0 : en_next;
    end
    always_ff @(posedge core_clk) begin
        rd_data <= cpu_rd && cpu_addr == `JCU_ADDR_DATA;
        rd_ctrl <= cpu_rd && cpu_addr == `JCU_ADDR_CTRL;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    // ****
    // properties
    // ****
    a_read_answered: assert property (map_rd |=> cpu_rvalid)
        else $error("mapped read got no answer");
    a_rvalid_cause: assert property (cpu_rvalid |-> $past(map_rd))
        else $error("answer without a mapped read");
    a_rdata_idle: assert property (!cpu_rvalid |-> cpu_rdata == 32'h0)
        else $error("read data not zero while idle");
    a_data_unused: assert property (cpu_rvalid && rd_data |-> cpu_rdata[14:8] == 7'h0)
        else $error("unused data bits not zero");
    a_ctrl_unused: assert property (cpu_rvalid && rd_ctrl |->
        cpu_rdata[15:11] == 5'h0 && cpu_rdata[7:2] == 6'h0)
        else $error("unused control bits not zero");
    a_count_valid: assert property (cpu_rvalid && rd_data && cpu_rdata[31:16] != 16'h0 |->
        cpu_rdata[15] && cpu_rdata[31:16] < 16'h40)
        else $error("fill count without valid flag");
    a_space_bound: assert property (cpu_rvalid && rd_ctrl |-> cpu_rdata[31:16] <= 16'h40)
        else $error("free space above queue size");
    a_irq_disabled: assert property ($past(en_reg) == 2'h0 && $past(en_reg, 2) == 2'h0 |-> !irq)
        else $error("interrupt while disabled");
    a_link_idle: assert property (!link_sel [*8] |-> !link_tdo)
        else $error("link output busy outside a frame");
    a_irq_level: assert property (cpu_rvalid && rd_ctrl |->
        irq == (cpu_rdata[9] || cpu_rdata[8]))
        else $error("interrupt differs from pending flags");
endmodule

bind jcu_top jcu_top_props i_jcu_top_props (
    .core_clk(core_clk), .srst(srst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .irq(irq), .link_tck(link_tck), .link_sel(link_sel), .link_tdi(link_tdi),
    .link_tdo(link_tdo)
);

/* test/jcu_host_model.sv */
// host end of the debug link: one byte in and one byte out per frame
`timescale 1ns/100ps

module jcu_host_model (
    // link pins
    output logic link_tck,
    output logic link_sel,
    output logic link_tdi,
    input wire logic link_tdo
);
    initial begin
        link_tck = 1'b0;
        link_sel = 1'b0;
        link_tdi = 1'b1;
    end

    // ****
    // frame: fewer than ten rises gives a frame the device must ignore
    // ****
    task automatic frame(input int rises, input logic [9:0] bits, output logic offered,
                         output logic [7:0] got);
        int i;
        got = 8'h0;
        link_sel = 1'b1;
        #62.5;
        offered = link_tdo;
        for (i = 0; i < rises; i++) begin
            link_tdi = bits[i];
            #62.5;
            if (i >= 1 && i <= 8) begin
                got[i - 1] = link_tdo;
            end
            link_tck = 1'b1;
            #62.5;
            link_tck = 1'b0;
        end
        #62.5;
        link_sel = 1'b0;
        // released line flips so a stale bit cannot be mistaken for data
        link_tdi = ~link_tdi;
        #100;
    endtask
endmodule

/* test/jcu_top_tb.sv */
// self-checking bench for the debug-link character uart
`timescale 1ns/100ps
`include "jcu_params.svh"

module jcu_top_tb;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic [31:0] cpu_addr = 32'h0;
    logic [31:0] cpu_wdata = 32'h0;
    logic [31:0] cpu_rdata;
    logic cpu_rvalid, irq, link_tck, link_sel, link_tdi, link_tdo, offered;
    logic [7:0] got, ch;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] tx_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 10512;
    int i;

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    jcu_top i_jcu_top (.core_clk(core_clk), .srst(srst), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .irq(irq), .link_tck(link_tck), .link_sel(link_sel),
        .link_tdi(link_tdi), .link_tdo(link_tdo));
    jcu_host_model i_jcu_host_model (.link_tck(link_tck), .link_sel(link_sel),
        .link_tdi(link_tdi), .link_tdo(link_tdo));

    // ****
    // tasks
    // ****
    task automatic chk32(input logic [31:0] act, input logic [31:0] exp, input logic [31:0] msk);
        total_checks++;
        if ((act & msk) !== (exp & msk)) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic wr, input logic rd);
        @(negedge core_clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = wr;
        cpu_rd = rd;
        @(negedge core_clk);
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
    endtask

    task automatic reg_rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(a, 32'h0, 1'b0, 1'b1);
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // answers are matched oldest first; an unasked answer is a mismatch
    always @(negedge core_clk) begin
        if (cpu_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk32({31'h0, cpu_rvalid}, 32'h0, 32'h1);
            end else begin
                chk32(cpu_rdata, exp_q.pop_front(), msk_q.pop_front());
            end
        end
    end

    initial begin
        #300000;
        error_cnt++;
        finish_test();
    end

    // ****
    // scenarios
    // ****
    initial begin
        repeat (5) @(negedge core_clk);
        srst = 1'b0;
        repeat (3) @(negedge core_clk);
        reg_rd(`JCU_ADDR_CTRL, 32'h0040_0000, '1);
        reg_rd(`JCU_ADDR_DATA, 32'h0, 32'hffff_ff00);
        bus(32'hff20_1008, '1, 1'b1, 1'b0);
        bus(32'hff20_1008, 32'h0, 1'b0, 1'b1);
        bus(`JCU_ADDR_CTRL, 32'hffff_fbff, 1'b1, 1'b0);
        repeat (3) @(negedge core_clk);
        reg_rd(`JCU_ADDR_CTRL, 32'h0040_0203, '1);
        chk32({31'h0, irq}, 32'h1, 32'h1);
        bus(`JCU_ADDR_CTRL, 32'h1, 1'b1, 1'b0);
        i_jcu_host_model.frame(9, {8'h5a, 2'b01}, offered, got);
        reg_rd(`JCU_ADDR_DATA, 32'h0, 32'hffff_ff00);
        reg_rd(`JCU_ADDR_CTRL, 32'h0040_0001, '1);
        for (i = 0; i < 66; i++) begin
            ch = 8'($random(seed));
            if (i < 64) begin
                rx_q.push_back(ch);
            end
            i_jcu_host_model.frame(10, {ch, 2'b01}, offered, got);
            // seven held chars is the last level without a pending flag
            if (i == 6 || i == 7) begin
                reg_rd(`JCU_ADDR_CTRL, {16'h0040, 7'h02, (i == 7), 8'h01}, '1);
            end
        end
        reg_rd(`JCU_ADDR_CTRL, 32'h0040_0501, '1);
        for (i = 0; i < 65; i++) begin
            ch = 8'($random(seed));
            if (i < 64) begin
                tx_q.push_back(ch);
            end
            bus(`JCU_ADDR_DATA, {24'($random(seed)), ch}, 1'b1, 1'b0);
        end
        reg_rd(`JCU_ADDR_CTRL, 32'h0000_0501, '1);
        for (i = 0; i < 64; i++) begin
            reg_rd(`JCU_ADDR_DATA, {16'(63 - i), 8'h80, rx_q.pop_front()}, '1);
        end
        reg_rd(`JCU_ADDR_DATA, 32'h0, 32'hffff_ff00);
        reg_rd(`JCU_ADDR_CTRL, 32'h0000_0401, '1);
        bus(`JCU_ADDR_CTRL, 32'h0000_0401, 1'b1, 1'b0);
        reg_rd(`JCU_ADDR_CTRL, 32'h0000_0001, '1);
        for (i = 0; i < 64; i++) begin
            i_jcu_host_model.frame(10, 10'h2, offered, got);
            chk32({31'h0, offered}, 32'h1, 32'h1);
            chk32({24'h0, got}, {24'h0, tx_q.pop_front()}, 32'hff);
        end
        i_jcu_host_model.frame(10, 10'h2, offered, got);
        chk32({31'h0, offered}, 32'h0, 32'h1);
        reg_rd(`JCU_ADDR_CTRL, 32'h0040_0401, '1);
        repeat (4) @(negedge core_clk);
        finish_test();
    end
endmodule
